//--- src/snlc_pkg.sv
package snlc_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [7:0] SNLC_IDX_TILE0_DBG = 8'h10;
  localparam logic [7:0] SNLC_IDX_TILE1_DBG = 8'h11;
  localparam logic [7:0] SNLC_IDX_DBG_SRC = 8'h1f;
  localparam logic [7:0] SNLC_IDX_EXT_STATUS = 8'h20;
  localparam logic [7:0] SNLC_IDX_PP_STATUS = 8'h40;
  localparam logic [7:0] SNLC_IDX_EXT_CONFIG = 8'h80;
  localparam logic [7:0] SNLC_IDX_STATIC_FWD = 8'ha0;
  localparam int SNLC_NUM_LINKS = 8;

  // ------------------------------------------------------------
  // Debug line config and source fields
  // ------------------------------------------------------------
  localparam int SNLC_DBG_DRIVE_BIT = 0;
  localparam int SNLC_DBG_LISTEN_BIT = 1;
  localparam int SNLC_SRC_TILE0_BIT = 0;
  localparam int SNLC_SRC_TILE1_BIT = 1;
  localparam int SNLC_SRC_PIN_BIT = 4;

  // ------------------------------------------------------------
  // Link status fields
  // ------------------------------------------------------------
  localparam int SNLC_ST_TARGET_LSB = 24;
  localparam int SNLC_ST_DEST_LSB = 16;
  localparam int SNLC_ST_DIR_LSB = 8;
  localparam int SNLC_ST_NET_LSB = 4;
  localparam int SNLC_ST_JUNK_BIT = 2;
  localparam int SNLC_ST_DST_BIT = 1;
  localparam int SNLC_ST_SRC_BIT = 0;

  // ------------------------------------------------------------
  // Link config fields
  // ------------------------------------------------------------
  localparam int SNLC_CF_ENABLE_BIT = 31;
  localparam int SNLC_CF_WIDE_BIT = 30;
  localparam int SNLC_CF_ERROR_BIT = 27;
  localparam int SNLC_CF_GRANTED_BIT = 26;
  localparam int SNLC_CF_HOLDS_BIT = 25;
  localparam int SNLC_CF_GREET_BIT = 24;
  localparam int SNLC_CF_RXRST_BIT = 23;
  localparam int SNLC_CF_SYMGAP_LSB = 11;
  localparam int SNLC_CF_TOKGAP_LSB = 0;
  localparam int SNLC_GAP_W = 11;

  // ------------------------------------------------------------
  // Static forwarding fields
  // ------------------------------------------------------------
  localparam int SNLC_SF_ENABLE_BIT = 31;
  localparam int SNLC_SF_PROC_BIT = 8;
  localparam int SNLC_SF_CHAN_LSB = 0;
  localparam logic [2:0] SNLC_SF_ORDER_FLIP = 3'h2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0] SNLC_RST_DBG_CFG = 2'h0;
  localparam logic [3:0] SNLC_RST_DIR = 4'h0;
  localparam logic [1:0] SNLC_RST_NET = 2'h0;
  localparam logic SNLC_RST_ENABLE = 1'b0;
  localparam logic SNLC_RST_WIDE = 1'b0;
  localparam logic [10:0] SNLC_RST_GAP = 11'h000;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] target;
    logic [7:0] dest;
    logic junk;
    logic dst_busy;
    logic src_busy;
  } snlc_link_state_t;

  typedef struct packed {
    logic rx_error;
    logic credit_granted;
    logic credit_held;
  } snlc_link_credit_t;

  typedef struct packed {
    logic enable;
    logic proc;
    logic [4:0] chanend;
  } snlc_static_fwd_t;

endpackage

//--- src/snlc_pacer.sv
`timescale 1ns/100ps
module snlc_pacer
  import snlc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Gap settings
  input wire logic [SNLC_GAP_W-1:0] sym_gap,
  input wire logic [SNLC_GAP_W-1:0] tok_gap,
  // Symbol stream from the transmitter
  input wire logic sym_valid,
  input wire logic sym_last,
  output logic sym_ready
);

  logic [SNLC_GAP_W:0] idle_reg;
  logic [SNLC_GAP_W:0] idle_next;
  logic sent;

  assign sent = sym_valid & sym_ready;

  // ------------------------------------------------------------
  // Idle counter: gap plus one clocks after each symbol
  // ------------------------------------------------------------
  always_comb
  begin
    idle_next = idle_reg;
    if (sent && sym_last)
    begin
      idle_next = {1'b0, tok_gap} + 12'h001;
    end
    else if (sent)
    begin
      idle_next = {1'b0, sym_gap} + 12'h001;
    end
    else if (idle_reg != '0)
    begin
      idle_next = idle_reg - 12'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idle_reg <= '0;
      sym_ready <= 1'b0;
    end
    else
    begin
      idle_reg <= idle_next;
      sym_ready <= (idle_next == '0);
    end
  end

endmodule

//--- src/snlc_regs.sv
`timescale 1ns/100ps
module snlc_regs
  import snlc_pkg::*;
#(
  parameter int NUM_LINKS = SNLC_NUM_LINKS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared halt line, open drain, active low
  input wire logic shared_halt_line_in,
  output logic shared_halt_line_out,
  output logic shared_halt_line_oe,
  // Processor tiles
  input wire logic [1:0] halted_flag,
  output logic [1:0] halt_request,
  // Link state from the switch
  input snlc_link_state_t ext_state [NUM_LINKS],
  input snlc_link_state_t pp_state [NUM_LINKS],
  input snlc_link_credit_t ext_credit [NUM_LINKS],
  // Link control
  output logic [NUM_LINKS-1:0] link_enable,
  output logic [NUM_LINKS-1:0] link_wide,
  output logic [NUM_LINKS-1:0] link_greet,
  output logic [NUM_LINKS-1:0] link_rx_reset,
  output logic [3:0] ext_dir [NUM_LINKS],
  output logic [1:0] ext_net [NUM_LINKS],
  output logic [1:0] pp_net [NUM_LINKS],
  output snlc_static_fwd_t static_fwd [NUM_LINKS],
  // Transmit pacing
  input wire logic [NUM_LINKS-1:0] sym_valid,
  input wire logic [NUM_LINKS-1:0] sym_last,
  output logic [NUM_LINKS-1:0] sym_ready,
  // Routing lookup
  input wire logic [7:0] own_node_id,
  input wire logic [7:0] pkt_node_id,
  input wire logic [31:0] dir_table,
  output logic route_mismatch,
  output logic [3:0] route_dir
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic in_block(input logic [7:0] idx, input logic [7:0] base);
    in_block = (idx >= base) && (idx < base + 8'(NUM_LINKS));
  endfunction

  function automatic logic [2:0] static_link(input logic [2:0] slot);
    static_link = slot ^ SNLC_SF_ORDER_FLIP;
  endfunction

  function automatic logic [3:0] msb_dir(input logic [7:0] diff, input logic [31:0] table_w);
    logic [3:0] d;
    d = 4'h0;
    for (int b = 0; b < 8; b++)
    begin
      if (diff[b])
      begin
        d = table_w[4*b +: 4];
      end
    end
    msb_dir = d;
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [1:0] dbg_cfg_reg [2];
  logic [2:0] dbg_src_reg;
  logic [3:0] dir_reg [NUM_LINKS];
  logic [1:0] ext_net_reg [NUM_LINKS];
  logic [1:0] pp_net_reg [NUM_LINKS];
  logic [NUM_LINKS-1:0] enable_reg;
  logic [NUM_LINKS-1:0] wide_reg;
  logic [SNLC_GAP_W-1:0] sym_gap_reg [NUM_LINKS];
  logic [SNLC_GAP_W-1:0] tok_gap_reg [NUM_LINKS];
  snlc_static_fwd_t fwd_reg [NUM_LINKS];

  // ------------------------------------------------------------
  // APB handshake
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic hit_hi;
  logic wr_now;
  logic [2:0] lane;
  logic mapped;

  assign idx = paddr[9:2];
  assign hit_hi = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  assign wr_now = psel & penable & pready & pwrite & mapped;
  assign lane = idx[2:0];

  always_comb
  begin
    mapped = hit_hi && ((idx == SNLC_IDX_TILE0_DBG) || (idx == SNLC_IDX_TILE1_DBG)
      || (idx == SNLC_IDX_DBG_SRC) || in_block(idx, SNLC_IDX_EXT_STATUS)
      || in_block(idx, SNLC_IDX_PP_STATUS) || in_block(idx, SNLC_IDX_EXT_CONFIG)
      || in_block(idx, SNLC_IDX_STATIC_FWD));
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [31:0] rd_word;
  snlc_link_state_t st_sel;

  assign st_sel = idx[6] ? pp_state[lane] : ext_state[lane];

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (idx == SNLC_IDX_TILE0_DBG || idx == SNLC_IDX_TILE1_DBG)
    begin
      rd_word[1:0] = dbg_cfg_reg[idx[0]];
    end
    else if (idx == SNLC_IDX_DBG_SRC)
    begin
      rd_word[SNLC_SRC_PIN_BIT] = dbg_src_reg[2];
      rd_word[SNLC_SRC_TILE1_BIT] = dbg_src_reg[1];
      rd_word[SNLC_SRC_TILE0_BIT] = dbg_src_reg[0];
    end
    else if (in_block(idx, SNLC_IDX_EXT_STATUS) || in_block(idx, SNLC_IDX_PP_STATUS))
    begin
      rd_word[SNLC_ST_TARGET_LSB +: 2] = st_sel.target;
      rd_word[SNLC_ST_DEST_LSB +: 8] = st_sel.dest;
      rd_word[SNLC_ST_JUNK_BIT] = st_sel.junk;
      rd_word[SNLC_ST_DST_BIT] = st_sel.dst_busy;
      rd_word[SNLC_ST_SRC_BIT] = st_sel.src_busy;
      rd_word[SNLC_ST_NET_LSB +: 2] = idx[6] ? pp_net_reg[lane] : ext_net_reg[lane];
      if (!idx[6])
      begin
        rd_word[SNLC_ST_DIR_LSB +: 4] = dir_reg[lane];
      end
    end
    else if (in_block(idx, SNLC_IDX_EXT_CONFIG))
    begin
      rd_word[SNLC_CF_ENABLE_BIT] = enable_reg[lane];
      rd_word[SNLC_CF_WIDE_BIT] = wide_reg[lane];
      rd_word[SNLC_CF_ERROR_BIT] = ext_credit[lane].rx_error;
      rd_word[SNLC_CF_GRANTED_BIT] = ext_credit[lane].credit_granted;
      rd_word[SNLC_CF_HOLDS_BIT] = ext_credit[lane].credit_held;
      rd_word[SNLC_CF_SYMGAP_LSB +: SNLC_GAP_W] = sym_gap_reg[lane];
      rd_word[SNLC_CF_TOKGAP_LSB +: SNLC_GAP_W] = tok_gap_reg[lane];
    end
    else if (in_block(idx, SNLC_IDX_STATIC_FWD))
    begin
      rd_word[SNLC_SF_ENABLE_BIT] = fwd_reg[static_link(lane)].enable;
      rd_word[SNLC_SF_PROC_BIT] = fwd_reg[static_link(lane)].proc;
      rd_word[SNLC_SF_CHAN_LSB +: 5] = fwd_reg[static_link(lane)].chanend;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite && mapped)
      begin
        prdata <= rd_word;
      end
      else if (psel && penable && !pready)
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Debug line configuration
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dbg_cfg_reg[0] <= SNLC_RST_DBG_CFG;
      dbg_cfg_reg[1] <= SNLC_RST_DBG_CFG;
    end
    else if (wr_now && (idx == SNLC_IDX_TILE0_DBG || idx == SNLC_IDX_TILE1_DBG))
    begin
      dbg_cfg_reg[idx[0]] <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Shared halt line and event source
  // ------------------------------------------------------------
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic [1:0] tile_drive;
  logic line_active;
  logic line_prev_reg;
  logic pin_only;

  assign tile_drive[0] = halted_flag[0] & dbg_cfg_reg[0][SNLC_DBG_DRIVE_BIT];
  assign tile_drive[1] = halted_flag[1] & dbg_cfg_reg[1][SNLC_DBG_DRIVE_BIT];
  assign pin_only = ~pin_sync_reg & ~shared_halt_line_oe;
  assign line_active = shared_halt_line_oe | ~pin_sync_reg;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
      line_prev_reg <= 1'b0;
      shared_halt_line_out <= 1'b0;
      shared_halt_line_oe <= 1'b0;
      halt_request <= 2'h0;
    end
    else
    begin
      pin_meta_reg <= shared_halt_line_in;
      pin_sync_reg <= pin_meta_reg;
      line_prev_reg <= line_active;
      shared_halt_line_out <= 1'b0;
      shared_halt_line_oe <= |tile_drive;
      halt_request[0] <= line_active & dbg_cfg_reg[0][SNLC_DBG_LISTEN_BIT];
      halt_request[1] <= line_active & dbg_cfg_reg[1][SNLC_DBG_LISTEN_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dbg_src_reg <= 3'h0;
    end
    else if (line_active && !line_prev_reg)
    begin
      dbg_src_reg[2] <= pin_only;
      dbg_src_reg[1] <= shared_halt_line_oe & tile_drive[1];
      dbg_src_reg[0] <= shared_halt_line_oe & tile_drive[0];
    end
    else if (wr_now && idx == SNLC_IDX_DBG_SRC)
    begin
      dbg_src_reg <= {pwdata[SNLC_SRC_PIN_BIT], pwdata[SNLC_SRC_TILE1_BIT],
        pwdata[SNLC_SRC_TILE0_BIT]};
    end
  end

  // ------------------------------------------------------------
  // Link status direction and network
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        dir_reg[i] <= SNLC_RST_DIR;
        ext_net_reg[i] <= SNLC_RST_NET;
        pp_net_reg[i] <= SNLC_RST_NET;
      end
    end
    else if (wr_now && in_block(idx, SNLC_IDX_EXT_STATUS))
    begin
      dir_reg[lane] <= pwdata[SNLC_ST_DIR_LSB +: 4];
      ext_net_reg[lane] <= pwdata[SNLC_ST_NET_LSB +: 2];
    end
    else if (wr_now && in_block(idx, SNLC_IDX_PP_STATUS))
    begin
      pp_net_reg[lane] <= pwdata[SNLC_ST_NET_LSB +: 2];
    end
  end

  // ------------------------------------------------------------
  // Link configuration
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_reg <= '0;
      wide_reg <= '0;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        sym_gap_reg[i] <= SNLC_RST_GAP;
        tok_gap_reg[i] <= SNLC_RST_GAP;
      end
    end
    else if (wr_now && in_block(idx, SNLC_IDX_EXT_CONFIG))
    begin
      enable_reg[lane] <= pwdata[SNLC_CF_ENABLE_BIT];
      wide_reg[lane] <= pwdata[SNLC_CF_WIDE_BIT];
      sym_gap_reg[lane] <= pwdata[SNLC_CF_SYMGAP_LSB +: SNLC_GAP_W];
      tok_gap_reg[lane] <= pwdata[SNLC_CF_TOKGAP_LSB +: SNLC_GAP_W];
    end
  end

  // Write-only commands as one-cycle pulses
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_greet <= '0;
      link_rx_reset <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        link_greet[i] <= wr_now && in_block(idx, SNLC_IDX_EXT_CONFIG)
          && lane == 3'(i) && pwdata[SNLC_CF_GREET_BIT];
        link_rx_reset[i] <= wr_now && in_block(idx, SNLC_IDX_EXT_CONFIG)
          && lane == 3'(i) && pwdata[SNLC_CF_RXRST_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Static forwarding
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        fwd_reg[i] <= '0;
      end
    end
    else if (wr_now && in_block(idx, SNLC_IDX_STATIC_FWD))
    begin
      fwd_reg[static_link(lane)].enable <= pwdata[SNLC_SF_ENABLE_BIT];
      fwd_reg[static_link(lane)].proc <= pwdata[SNLC_SF_PROC_BIT];
      fwd_reg[static_link(lane)].chanend <= pwdata[SNLC_SF_CHAN_LSB +: 5];
    end
  end

  // ------------------------------------------------------------
  // Registered control outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_enable <= '0;
      link_wide <= '0;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        ext_dir[i] <= SNLC_RST_DIR;
        ext_net[i] <= SNLC_RST_NET;
        pp_net[i] <= SNLC_RST_NET;
        static_fwd[i] <= '0;
      end
    end
    else
    begin
      link_enable <= enable_reg;
      link_wide <= wide_reg;
      for (int i = 0; i < NUM_LINKS; i++)
      begin
        ext_dir[i] <= dir_reg[i];
        ext_net[i] <= ext_net_reg[i];
        pp_net[i] <= pp_net_reg[i];
        static_fwd[i] <= fwd_reg[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Routing lookup
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      route_mismatch <= 1'b0;
      route_dir <= 4'h0;
    end
    else
    begin
      route_mismatch <= |(own_node_id ^ pkt_node_id);
      route_dir <= msb_dir(own_node_id ^ pkt_node_id, dir_table);
    end
  end

  // ------------------------------------------------------------
  // Transmit pacing per link
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_LINKS; g++)
  begin : g_pace
    snlc_pacer u_pacer (
      .clk(clk),
      .reset_n(reset_n),
      .sym_gap(sym_gap_reg[g]),
      .tok_gap(tok_gap_reg[g]),
      .sym_valid(sym_valid[g]),
      .sym_last(sym_last[g]),
      .sym_ready(sym_ready[g])
    );
  end

endmodule

//--- test/snlc_checker.sv
`timescale 1ns/100ps
module snlc_checker
  import snlc_pkg::*;
#(
  parameter int NUM_LINKS = SNLC_NUM_LINKS
)
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Halt line
  input wire logic shared_halt_line_in,
  input wire logic shared_halt_line_out,
  input wire logic shared_halt_line_oe,
  input wire logic [1:0] halted_flag,
  input wire logic [1:0] halt_request,
  // Links and routing
  input wire logic [NUM_LINKS-1:0] link_greet,
  input wire logic [NUM_LINKS-1:0] link_rx_reset,
  input wire logic [NUM_LINKS-1:0] sym_valid,
  input wire logic [NUM_LINKS-1:0] sym_ready,
  input wire logic [7:0] own_node_id,
  input wire logic [7:0] pkt_node_id,
  input wire logic route_mismatch
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------
  // Sequences
  // ------------------------------------------------
  sequence s_first_access;
    psel && $rose(penable);
  endsequence
  sequence s_cfg_write;
    pready && pwrite && !pslverr && paddr[9:5] == 5'h10;
  endsequence
  // ------------------------------------------------
  // Properties
  // ------------------------------------------------
  a_ready_after_access: assert property (s_first_access |=> pready)
    else $error("pready late");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held");
  a_misaligned_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access accepted");
  a_greet_pulse: assert property (s_cfg_write |=>
    link_greet == ({7'h0, $past(pwdata[24])} << $past(paddr[4:2])))
    else $error("greeting pulse wrong");
  a_rx_reset_pulse: assert property (s_cfg_write |=>
    link_rx_reset == ({7'h0, $past(pwdata[23])} << $past(paddr[4:2])))
    else $error("receiver reset pulse wrong");
  a_line_drive_cause: assert property (shared_halt_line_oe |->
    $past(halted_flag) != 2'h0 && !shared_halt_line_out)
    else $error("line driven without halted tile");
  a_halt_req_cause: assert property (halt_request != 2'h0 |-> $past(shared_halt_line_oe)
    || !$past(shared_halt_line_in, 2) || !$past(shared_halt_line_in, 3))
    else $error("halt request without active line");
  a_symbol_idle: assert property (sym_valid[0] && sym_ready[0] |=> !sym_ready[0])
    else $error("no idle clock after symbol");
  a_route_flag: assert property ($past(reset_n) |->
    route_mismatch == $past(own_node_id != pkt_node_id))
    else $error("route mismatch flag wrong");
endmodule

//--- test/snlc_far_end.sv
`timescale 1ns/100ps
module snlc_far_end
  import snlc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link state toward the switch
  output snlc_link_state_t ext_state [8],
  output snlc_link_state_t pp_state [8],
  output snlc_link_credit_t ext_credit [8],
  // Symbol stream
  input wire logic run,
  input wire logic [7:0] sym_ready,
  output logic [7:0] sym_valid,
  output logic [7:0] sym_last,
  // Spacing seen on link 0
  output int gap_sym,
  output int gap_tok
);
  logic [7:0][1:0] cnt;
  logic prev_last;
  int age;
  // Tokens of three symbols; valid held until taken
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      ext_state[i] = '{i[1:0], 8'h30 + 8'(i), i[0], i[1], i[2]};
      pp_state[i] = '{~i[1:0], 8'h50 + 8'(i), i[2], i[0], i[1]};
      ext_credit[i] = snlc_link_credit_t'(i[2:0]);
      sym_last[i] = cnt[i] == 2'h2;
    end
    sym_valid = {8{run}};
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= '0;
      age <= 0;
      prev_last <= 1'b1;
      gap_sym <= 0;
      gap_tok <= 0;
    end
    else
    begin
      age <= age + 1;
      for (int i = 0; i < 8; i++)
        if (sym_valid[i] && sym_ready[i])
          cnt[i] <= (cnt[i] == 2'h2) ? 2'h0 : cnt[i] + 2'h1;
      if (sym_valid[0] && sym_ready[0])
      begin
        age <= 1;
        prev_last <= sym_last[0];
        if (prev_last)
          gap_tok <= age;
        else
          gap_sym <= age;
      end
    end
  end
endmodule

//--- test/test_snlc_regs.sv
`timescale 1ns/100ps
module test_snlc_regs;
  import snlc_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, ext_low, run, line_in, line_out, line_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, dtab, v;
  logic pready, pslverr, mism;
  logic [1:0] halted, hreq;
  logic [3:0] rdir, ed;
  snlc_link_state_t est [8], pst [8];
  snlc_link_credit_t cred [8];
  logic [7:0] en, wide, greet, rxr, sv, sl, sr, own, pkt;
  logic [3:0] dir [8];
  logic [1:0] enet [8], pnet [8];
  snlc_static_fwd_t sf [8];
  logic [11:0] bad [4] = '{12'h0a0, 12'h220, 12'h201, 12'h480};
  int gs, gt, fail_count, tests_run, cyc;
  logic [32:0] exp_q [$];
  assign line_in = line_oe ? line_out : !ext_low;
  snlc_regs u_snlc_regs (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .shared_halt_line_in(line_in), .shared_halt_line_out(line_out),
    .shared_halt_line_oe(line_oe), .halted_flag(halted), .halt_request(hreq),
    .ext_state(est), .pp_state(pst), .ext_credit(cred), .link_enable(en),
    .link_wide(wide), .link_greet(greet), .link_rx_reset(rxr), .ext_dir(dir),
    .ext_net(enet), .pp_net(pnet), .static_fwd(sf), .sym_valid(sv), .sym_last(sl),
    .sym_ready(sr), .own_node_id(own), .pkt_node_id(pkt), .dir_table(dtab),
    .route_mismatch(mism), .route_dir(rdir));
  snlc_far_end u_snlc_far_end (.clk(clk), .reset_n(reset_n), .ext_state(est),
    .pp_state(pst), .ext_credit(cred), .run(run), .sym_ready(sr), .sym_valid(sv),
    .sym_last(sl), .gap_sym(gs), .gap_tok(gt));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrd(input logic [7:0] idx, input logic [31:0] d, e0, e1);
    apb(1'b0, ad(idx), 32'h0, {1'b0, e0});
    apb(1'b1, ad(idx), d, 33'h0);
    apb(1'b0, ad(idx), 32'h0, {1'b0, e1});
  endtask
  task automatic hstep(input logic [1:0] h, input logic x, r, input logic [31:0] s);
    halted <= h;
    ext_low <= x;
    repeat (6) @(posedge clk);
    chk("halt_request", hreq, {2{r}});
    apb(1'b0, ad(8'h1f), 32'h0, {1'b0, s});
  endtask
  function automatic logic [31:0] stv(snlc_link_state_t s, logic [3:0] d, logic [1:0] n);
    return {6'h0, s.target, s.dest, 4'h0, d, 2'h0, n, 1'b0, s.junk, s.dst_busy, s.src_busy};
  endfunction
  always @(posedge clk)
  begin
    cyc++;
    if (pready === 1'b1)
      chk("bus reply", {pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
    if (cyc == 20000)
    begin
      fail_count++;
      results();
    end
  end
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, run, ext_low, reset_n} = '0;
    {paddr, pwdata, halted, own, pkt, dtab} = '0;
    {fail_count, tests_run, cyc} = '0;
    void'($urandom(32'ha1d7));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom;
      wrd(8'h20 + 8'(i), v, stv(est[i], 4'h0, 2'h0), stv(est[i], v[11:8], v[5:4]));
      wrd(8'h40 + 8'(i), v, stv(pst[i], 4'h0, 2'h0), stv(pst[i], 4'h0, v[5:4]));
      wrd(8'h80 + 8'(i), v, {4'h0, cred[i], 25'h0},
        {v[31:30], 2'h0, cred[i], 3'h0, v[21:0]});
      wrd(8'ha0 + 8'(i), v, 32'h0, {v[31], 22'h0, v[8], 3'h0, v[4:0]});
      chk("static_fwd", sf[i ^ 2], {v[31], v[8], v[4:0]});
      chk("ext_dir", dir[i], v[11:8]);
      chk("net", {enet[i], pnet[i]}, {2{v[5:4]}});
      chk("enable_wide", {en[i], wide[i]}, v[31:30]);
    end
    v = $urandom;
    wrd(8'h10, v, 32'h0, v & 32'h3);
    wrd(8'h11, v, 32'h0, v & 32'h3);
    wrd(8'h1f, v, 32'h0, v & 32'h13);
    foreach (bad[j])
      apb(1'(j), bad[j], 32'h0, {1'b1, 32'h0});
    apb(1'b1, ad(8'h1f), 32'h0, 33'h0);
    apb(1'b1, ad(8'h10), 32'h3, 33'h0);
    apb(1'b1, ad(8'h11), 32'h2, 33'h0);
    hstep(2'b01, 1'b0, 1'b1, 32'h1);
    hstep(2'b10, 1'b0, 1'b0, 32'h1);
    apb(1'b1, ad(8'h1f), 32'h0, 33'h0);
    apb(1'b1, ad(8'h11), 32'h3, 33'h0);
    hstep(2'b10, 1'b0, 1'b1, 32'h2);
    hstep(2'b00, 1'b0, 1'b0, 32'h2);
    apb(1'b1, ad(8'h1f), 32'h0, 33'h0);
    hstep(2'b00, 1'b1, 1'b1, 32'h10);
    ext_low <= 1'b0;
    apb(1'b1, ad(8'h80), 32'h80001805, 33'h0);
    run <= 1'b1;
    repeat (80) @(posedge clk);
    chk("symbol_gap", 33'(gs), 33'd5);
    chk("token_gap", 33'(gt), 33'd7);
    for (int k = 0; k < 16; k++)
    begin
      v = $urandom;
      own <= v[7:0];
      pkt <= (k == 0) ? v[7:0] : 8'($urandom);
      dtab <= $urandom;
      @(posedge clk);
      @(posedge clk);
      ed = 4'h0;
      for (int b = 0; b < 8; b++)
        if (own[b] != pkt[b])
          ed = dtab[4 * b +: 4];
      chk("route", {mism, rdir}, {own != pkt, ed});
    end
    results();
  end
endmodule
bind snlc_regs snlc_checker #(.NUM_LINKS(NUM_LINKS)) u_snlc_checker (.*);
